//--- inc/mailbox_page_regs.svh
/*
  Byte offsets, limits and reset values of the command mailbox page.
  Assumes the page occupies upper-memory offsets 128..255 of the
  selected page.
*/
`ifndef MAILBOX_PAGE_REGS_SVH
`define MAILBOX_PAGE_REGS_SVH

`define OFS_CMD_HIGH 8'h80
`define OFS_CMD_LOW 8'h81
`define OFS_EXT_HIGH 8'h82
`define OFS_EXT_LOW 8'h83
`define OFS_LOC_LEN 8'h84
`define OFS_CHECK 8'h85
`define OFS_RSP_LEN 8'h86
`define OFS_RSP_CHK 8'h87
`define OFS_PAYLOAD 8'h88

`define PAYLOAD_BYTES 8'h78
`define EXT_LEN_MAX 16'h0800
`define RSP_RSV_HI 8'hEF
`define CHK_NONE 8'hFF
`define RESET_BYTE 8'h00

`endif

//--- inc/mailbox_pkg.sv
/*
  Types shared by the mailbox page and its payload store.
  Assumes nothing beyond a SystemVerilog package scope.
*/
package mailbox_pkg;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CHECK = 2'b01,
    ST_EXEC  = 2'b10,
    ST_RSUM  = 2'b11
  } state_e;

  typedef logic [7:0] byte_t;

endpackage

//--- inc/payload_if.sv
/*
  Single-port access to the local payload store.
  Assumes one requester drives it per cycle; read data lags by one edge.
*/
`timescale 1ns/1ps
interface payload_if;
  logic en;
  logic we;
  logic [6:0] addr;
  mailbox_pkg::byte_t wdata;
  mailbox_pkg::byte_t rdata;

  modport ctrl (output en, we, addr, wdata, input rdata);
  modport mem (input en, we, addr, wdata, output rdata);
endinterface

//--- src/payload_mem.sv
/*
  Local payload store, one byte per index, registered read data.
  Assumes clk and synchronous active-low rst_n of the page logic.
*/
`timescale 1ns/1ps
`include "mailbox_page_regs.svh"
module payload_mem #(
  parameter int DEPTH = 120
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access port
  payload_if.mem port
);
  mailbox_pkg::byte_t store [DEPTH];

  // array has no reset: contents are undefined until written
  always_ff @(posedge clk) begin
    if (port.en && port.we) begin
      store[port.addr] <= port.wdata;
    end
  end

  // read data from a flop so the scanner sees fixed latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port.rdata <= `RESET_BYTE;
    end else if (port.en && !port.we) begin
      port.rdata <= store[port.addr];
    end
  end
endmodule

//--- src/command_block_mailbox_page.sv
/*
  Command mailbox page: header bytes, local payload, command check,
  trigger and response reporting. Assumes a two-wire bus slave in the
  same clock domain delivers one-cycle byte strobes and a stop pulse,
  and a command engine answers cmd_start with rsp_done.
*/
//
// Function
// R1: writing the low command byte starts the held command.
// R2: host fills lengths, check code, payload, high byte before low byte.
// R3: host checks busy before a new command; else outcome undefined.
// R4: extended length is 16 bits, high at 130, valid 0 to 2048.
// R5: local payload sits at 136..255, at most 120 bytes, length at 132.
// R6: host check code is inverted byte sum, offsets 133..135 as zero.
// R7: host writes zero to the response length when issuing.
// R8: no response data gives response length zero and check zero.
// R9: payload without computable check gives length zero, check FFh.
// R10: length zero never pairs with check 01h..FEh.
// R11: lengths 1..120 report count and inverted sum of response bytes.
// R12: page exists only when the feature is advertised.
// R13: reserved lengths 121..239 carry check code zero.
// R14: config bit picks trigger on byte write or on bus stop.
// R15: recompute command check on trigger; mismatch fails the command.
`timescale 1ns/1ps
`include "mailbox_page_regs.svh"
module command_block_mailbox_page #(
  parameter int PAYLOAD_DEPTH = 120
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // page byte access from the bus slave
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_stop,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // configuration straps
  input wire logic trigger_at_stop,
  input wire logic block_implemented,
  // command engine side
  output logic cmd_start,
  output logic [15:0] cmd_code,
  output logic [15:0] ext_len,
  output logic [7:0] loc_len,
  output logic busy,
  output logic cmd_fail,
  input wire logic rsp_wr,
  input wire logic [6:0] rsp_idx,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_done,
  input wire logic [7:0] rsp_len_in,
  input wire logic rsp_chk_supported,
  input wire logic [7:0] rsp_epl_chk
);
  mailbox_pkg::state_e state, next_state;
  mailbox_pkg::byte_t check_code, rsp_len, rsp_chk, rsp_len_hold;
  mailbox_pkg::byte_t hdr_sum, sum, hdr_rd, rd_hdr;
  logic [6:0] scan_idx, scan_len, pay_idx;
  logic scan_vld, scan_issue, scan_done, armed, rd_pend, rd_mem;
  logic is_pay, acc_wr, write_low, start_now, lens_ok, check_ok;
  logic rsp_need_sum;

  payload_if pif ();

  payload_mem #(.DEPTH(PAYLOAD_DEPTH)) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .port(pif.mem)
  );

  // the whole page is invisible unless the feature is advertised
  assign acc_wr = bus_wr && block_implemented; // R12
  assign is_pay = bus_addr >= `OFS_PAYLOAD; // R5
  assign pay_idx = 7'(bus_addr - `OFS_PAYLOAD);
  assign write_low = acc_wr && bus_addr == `OFS_CMD_LOW;

  // trigger point chosen by the configuration strap
  // a stop-mode arm left over must not start a hidden page
  assign start_now = block_implemented && state == mailbox_pkg::ST_IDLE &&
    ((!trigger_at_stop && write_low) || // R1
     (trigger_at_stop && bus_stop && (armed || write_low))); // R14

  // stop-mode arm: a low-byte write waits for the end of its transfer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (bus_stop || !trigger_at_stop) begin
      armed <= 1'b0;
    end else if (write_low && state == mailbox_pkg::ST_IDLE) begin
      armed <= 1'b1; // R14
    end
  end

  // header bytes that take part in the command check
  assign hdr_sum = cmd_code[15:8] + cmd_code[7:0] + ext_len[15:8] +
    ext_len[7:0] + loc_len; // R6
  assign lens_ok = ext_len <= `EXT_LEN_MAX && loc_len <= `PAYLOAD_BYTES; // R4
  assign check_ok = lens_ok && 8'(~(hdr_sum + sum)) == check_code; // R15
  assign rsp_need_sum = rsp_len_in != `RESET_BYTE &&
    rsp_len_in <= `PAYLOAD_BYTES && rsp_chk_supported;

  // payload scanner shared by command check and response check
  always_comb begin
    if (state == mailbox_pkg::ST_CHECK) begin
      scan_len = lens_ok ? loc_len[6:0] : 7'h00; // R5
    end else begin
      scan_len = rsp_len_hold[6:0];
    end
  end
  assign scan_issue = (state == mailbox_pkg::ST_CHECK ||
    state == mailbox_pkg::ST_RSUM) && scan_idx < scan_len;
  assign scan_done = scan_idx == scan_len && !scan_vld;

  // byte sum, one payload byte per cycle after the read latency
  always_ff @(posedge clk) begin
    if (!rst_n || state == mailbox_pkg::ST_IDLE ||
        state == mailbox_pkg::ST_EXEC) begin
      scan_idx <= 7'h00;
      scan_vld <= 1'b0;
      sum <= `RESET_BYTE;
    end else begin
      scan_vld <= scan_issue;
      if (scan_issue) begin
        scan_idx <= scan_idx + 7'h01;
      end
      if (scan_vld) begin
        sum <= sum + pif.rdata;
      end
    end
  end

  // payload port owner follows the state: host, engine or scanner
  always_comb begin
    pif.en = 1'b0;
    pif.we = 1'b0;
    pif.addr = 7'h00;
    pif.wdata = `RESET_BYTE;
    case (state)
      mailbox_pkg::ST_IDLE: begin
        if (block_implemented && is_pay && (bus_wr || bus_rd)) begin
          pif.en = 1'b1;
          pif.we = bus_wr;
          pif.addr = pay_idx;
          pif.wdata = bus_wdata;
        end
      end
      mailbox_pkg::ST_EXEC: begin
        pif.en = rsp_wr;
        pif.we = rsp_wr;
        pif.addr = rsp_idx;
        pif.wdata = rsp_data;
      end
      default: begin
        pif.en = scan_issue;
        pif.addr = scan_idx;
      end
    endcase
  end

  // command sequencing
  always_comb begin
    next_state = state;
    case (state)
      mailbox_pkg::ST_IDLE: begin
        if (start_now) begin
          next_state = mailbox_pkg::ST_CHECK;
        end
      end
      mailbox_pkg::ST_CHECK: begin
        if (scan_done) begin
          next_state = check_ok ? mailbox_pkg::ST_EXEC :
            mailbox_pkg::ST_IDLE; // R15
        end
      end
      mailbox_pkg::ST_EXEC: begin
        if (rsp_done) begin
          next_state = rsp_need_sum ? mailbox_pkg::ST_RSUM :
            mailbox_pkg::ST_IDLE;
        end
      end
      mailbox_pkg::ST_RSUM: begin
        if (scan_done) begin
          next_state = mailbox_pkg::ST_IDLE;
        end
      end
      default: next_state = mailbox_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= mailbox_pkg::ST_IDLE;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      busy <= next_state != mailbox_pkg::ST_IDLE;
    end
  end

  // engine handshake: start pulse only after a clean check
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_start <= 1'b0;
      cmd_fail <= 1'b0;
    end else begin
      cmd_start <= state == mailbox_pkg::ST_CHECK && scan_done && check_ok;
      if (state == mailbox_pkg::ST_CHECK && scan_done) begin
        cmd_fail <= !check_ok; // R15
      end
    end
  end

  // host header writes; refused while a command runs (busy check)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_code <= {`RESET_BYTE, `RESET_BYTE};
      ext_len <= {`RESET_BYTE, `RESET_BYTE};
      loc_len <= `RESET_BYTE;
      check_code <= `RESET_BYTE;
    end else if (acc_wr && state == mailbox_pkg::ST_IDLE) begin
      case (bus_addr)
        `OFS_CMD_HIGH: cmd_code[15:8] <= bus_wdata;
        `OFS_CMD_LOW: cmd_code[7:0] <= bus_wdata;
        `OFS_EXT_HIGH: ext_len[15:8] <= bus_wdata; // R4
        `OFS_EXT_LOW: ext_len[7:0] <= bus_wdata;
        `OFS_LOC_LEN: loc_len <= bus_wdata;
        `OFS_CHECK: check_code <= bus_wdata;
        default: ;
      endcase
    end
  end

  // response fields: device result wins over a host write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_len <= `RESET_BYTE;
      rsp_chk <= `RESET_BYTE;
      rsp_len_hold <= `RESET_BYTE;
    end else if (state == mailbox_pkg::ST_CHECK && scan_done && !check_ok) begin
      rsp_len <= `RESET_BYTE;
      rsp_chk <= `RESET_BYTE;
    end else if (state == mailbox_pkg::ST_EXEC && rsp_done) begin
      rsp_len_hold <= rsp_len_in;
      if (rsp_len_in == `RESET_BYTE) begin
        rsp_len <= `RESET_BYTE; // R8
        rsp_chk <= `RESET_BYTE;
      end else if (rsp_len_in <= `PAYLOAD_BYTES) begin
        if (!rsp_chk_supported) begin
          rsp_len <= `RESET_BYTE; // R9
          rsp_chk <= `CHK_NONE; // R10
        end
      end else if (rsp_len_in <= `RSP_RSV_HI) begin
        rsp_len <= rsp_len_in; // R13
        rsp_chk <= `RESET_BYTE;
      end else begin
        rsp_len <= rsp_len_in;
        rsp_chk <= rsp_epl_chk;
      end
    end else if (state == mailbox_pkg::ST_RSUM && scan_done) begin
      rsp_len <= rsp_len_hold; // R11
      rsp_chk <= ~sum;
    end else if (acc_wr && state == mailbox_pkg::ST_IDLE) begin
      if (bus_addr == `OFS_RSP_LEN) begin
        rsp_len <= bus_wdata; // R7
      end
      if (bus_addr == `OFS_RSP_CHK) begin
        rsp_chk <= bus_wdata;
      end
    end
  end

  // header read mux; absent page and unmapped bytes read zero
  always_comb begin
    case (bus_addr)
      `OFS_CMD_HIGH: hdr_rd = cmd_code[15:8];
      `OFS_CMD_LOW: hdr_rd = cmd_code[7:0];
      `OFS_EXT_HIGH: hdr_rd = ext_len[15:8];
      `OFS_EXT_LOW: hdr_rd = ext_len[7:0];
      `OFS_LOC_LEN: hdr_rd = loc_len;
      `OFS_CHECK: hdr_rd = check_code;
      `OFS_RSP_LEN: hdr_rd = rsp_len;
      `OFS_RSP_CHK: hdr_rd = rsp_chk;
      default: hdr_rd = `RESET_BYTE;
    endcase
  end

  // two-stage read so payload and header bytes share one latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_pend <= 1'b0;
      rd_mem <= 1'b0;
      rd_hdr <= `RESET_BYTE;
      rd_valid <= 1'b0;
      rd_data <= `RESET_BYTE;
    end else begin
      rd_pend <= bus_rd;
      rd_mem <= bus_rd && block_implemented && is_pay &&
        state == mailbox_pkg::ST_IDLE;
      rd_hdr <= block_implemented ? hdr_rd : `RESET_BYTE; // R12
      rd_valid <= rd_pend;
      rd_data <= rd_mem ? pif.rdata : rd_hdr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_low_write_idle;
    write_low && state == mailbox_pkg::ST_IDLE;
  endsequence

  sequence seq_engine_done;
    state == mailbox_pkg::ST_EXEC && rsp_done;
  endsequence

  chk_start_on_write: assert property ( // R1
    seq_low_write_idle and !trigger_at_stop |=>
      state == mailbox_pkg::ST_CHECK)
    else $error("low byte write did not start the check");

  chk_stop_wait: assert property ( // R14
    seq_low_write_idle and trigger_at_stop && !bus_stop |=>
      state == mailbox_pkg::ST_IDLE && armed)
    else $error("stop mode started before the stop");

  chk_empty_response: assert property ( // R8
    seq_engine_done and rsp_len_in == 8'h00 |=>
      rsp_len == 8'h00 && rsp_chk == 8'h00 && !busy)
    else $error("empty response fields wrong");

  chk_unsupported_code: assert property ( // R9
    seq_engine_done and rsp_len_in != 8'h00 && rsp_len_in <= 8'h78 &&
      !rsp_chk_supported |=> rsp_len == 8'h00 && rsp_chk == 8'hFF)
    else $error("unsupported check code not FFh");

  chk_zero_len_pair: assert property ( // R10
    $past(state) != mailbox_pkg::ST_IDLE && state == mailbox_pkg::ST_IDLE &&
      rsp_len == 8'h00 |-> rsp_chk == 8'h00 || rsp_chk == 8'hFF)
    else $error("zero length with a middle check code");

  chk_response_sum: assert property ( // R11
    seq_engine_done and rsp_need_sum |=>
      state == mailbox_pkg::ST_RSUM ##[1:125] rsp_chk == ~sum &&
      rsp_len == rsp_len_hold)
    else $error("response check not reported in time");

  chk_reserved_len: assert property ( // R13
    seq_engine_done and rsp_len_in > 8'h78 && rsp_len_in <= 8'hEF |=>
      rsp_chk == 8'h00 && rsp_len == $past(rsp_len_in))
    else $error("reserved length carries a check code");

  chk_bad_check: assert property ( // R15
    state == mailbox_pkg::ST_CHECK && scan_done && !check_ok |=>
      cmd_fail && !cmd_start && state == mailbox_pkg::ST_IDLE)
    else $error("failed check still started the command");

  chk_ext_limit: assert property ( // R4
    state == mailbox_pkg::ST_CHECK && ext_len > 16'h0800 |->
      ##[0:2] state == mailbox_pkg::ST_IDLE)
    else $error("over-long extended length accepted");

  chk_absent_page: assert property ( // R12
    !block_implemented && state == mailbox_pkg::ST_IDLE |=>
      state == mailbox_pkg::ST_IDLE && !cmd_start)
    else $error("absent page started a command");
endmodule

//--- dv/mailbox_host.sv
/*
  Host model on the page byte bus: writes, reads, stop pulses and a
  whole command issue. Assumes the page clk; drives at falling edges.
*/
`timescale 1ns/1ps
module mailbox_host (
  // clock
  input wire logic clk,
  // page byte bus
  output logic [7:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [7:0] bus_wdata,
  output logic bus_stop,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic busy
);
  // idle bus from time zero
  initial begin
    bus_addr = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
    bus_stop = 1'b0;
  end

  // one-cycle write strobe, one idle cycle after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
  endtask

  // unknown result if the answer never comes, so a hang cannot pass
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 'x;
    @(negedge clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    repeat (4) begin
      if (rd_valid === 1'b1) begin
        d = rd_data;
      end
      @(negedge clk);
    end
  endtask

  // stop condition closing a write transaction
  task automatic stop();
    @(negedge clk);
    bus_stop = 1'b1;
    @(negedge clk);
    bus_stop = 1'b0;
  endtask

  // header and payload first, high byte, then the low byte last
  task automatic issue(input logic [15:0] cmd, input logic [15:0] ext,
                       input logic [7:0] ln, input logic bad);
    logic [7:0] sum;
    int n;
    sum = cmd[15:8] + cmd[7:0] + ext[15:8] + ext[7:0] + ln;
    for (n = 0; n < ln && n < 120; n++) begin
      sum = sum + 8'h30 + n[7:0];
    end
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    wr(8'h82, ext[15:8]);
    wr(8'h83, ext[7:0]);
    wr(8'h84, ln);
    wr(8'h85, ~sum ^ {7'h00, bad});
    wr(8'h86, 8'h00);
    wr(8'h87, 8'h00);
    for (n = 0; n < ln && n < 120; n++) begin
      wr(8'h88 + n[7:0], 8'h30 + n[7:0]);
    end
    wr(8'h80, cmd[15:8]);
    wr(8'h81, cmd[7:0]);
  endtask
endmodule

//--- dv/command_block_mailbox_page_test.sv
/*
  Self-checking bench for the command mailbox page: host model on the
  byte bus, command engine answers driven here. Assumes 25 MHz clk.
*/
`timescale 1ns/1ps
module command_block_mailbox_page_test;
  logic clk = 1'b0;
  logic rst_n;
  logic [7:0] bus_addr;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_wdata;
  logic bus_stop;
  logic [7:0] rd_data;
  logic rd_valid;
  logic trigger_at_stop;
  logic block_implemented;
  logic cmd_start;
  logic [15:0] cmd_code;
  logic [15:0] ext_len;
  logic [7:0] loc_len;
  logic busy;
  logic cmd_fail;
  logic rsp_wr;
  logic [6:0] rsp_idx;
  logic [7:0] rsp_data;
  logic rsp_done;
  logic [7:0] rsp_len_in;
  logic rsp_chk_supported;
  logic [7:0] rsp_epl_chk;
  logic [7:0] d;
  logic [7:0] rl [5] = '{8'h00, 8'h07, 8'h79, 8'h78, 8'hF3};
  logic rs [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  int i;

  command_block_mailbox_page command_block_mailbox_page_i (
    .clk, .rst_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_stop,
    .rd_data, .rd_valid, .trigger_at_stop, .block_implemented,
    .cmd_start, .cmd_code, .ext_len, .loc_len, .busy, .cmd_fail,
    .rsp_wr, .rsp_idx, .rsp_data, .rsp_done, .rsp_len_in,
    .rsp_chk_supported, .rsp_epl_chk);

  mailbox_host mailbox_host_i (
    .clk, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_stop,
    .rd_data, .rd_valid, .busy);

  // 40 ns period
  always #20 clk = ~clk;

  // hang guard, well above the fewer than one thousand cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  // a stale fail flag only counts once the check has finished
  task automatic wait_start(input logic ok);
    int n;
    n = 0;
    while (cmd_start !== 1'b1 && !(cmd_fail === 1'b1 && busy === 1'b0)
           && n < 300) begin
      @(negedge clk);
      n++;
    end
    check(cmd_start, ok);
    if (!ok) begin
      check(cmd_fail, 1'b1);
    end
  endtask

  // engine writes response bytes, finishes, then fields are read back
  task automatic respond(input logic [7:0] len, input logic sup);
    logic [7:0] sum;
    logic [7:0] el;
    logic [7:0] ec;
    int n;
    sum = 8'h00;
    for (n = 0; n < len && n < 120; n++) begin
      @(negedge clk);
      rsp_wr = 1'b1;
      rsp_idx = n[6:0];
      rsp_data = 8'h50 + n[7:0];
      sum = sum + rsp_data;
    end
    @(negedge clk);
    rsp_wr = 1'b0;
    rsp_done = 1'b1;
    rsp_len_in = len;
    rsp_chk_supported = sup;
    @(negedge clk);
    rsp_done = 1'b0;
    el = (len > 8'h78 || sup) ? len : 8'h00;
    ec = (len > 8'hEF) ? rsp_epl_chk :
      (len == 8'h00 || len > 8'h78) ? 8'h00 : (sup ? ~sum : 8'hFF);
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    mailbox_host_i.rd(8'h86, d);
    check(d, el);
    mailbox_host_i.rd(8'h87, d);
    check(d, ec);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    trigger_at_stop = 1'b0;
    block_implemented = 1'b1;
    rsp_wr = 1'b0;
    rsp_idx = 7'h00;
    rsp_data = 8'h00;
    rsp_done = 1'b0;
    rsp_len_in = 8'h00;
    rsp_chk_supported = 1'b0;
    rsp_epl_chk = 8'hA5;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    // header clear after reset, unmapped offset reads zero
    for (i = 0; i < 8; i++) begin
      mailbox_host_i.rd(8'h80 + i[7:0], d);
      check(d, 8'h00);
    end
    mailbox_host_i.rd(8'h10, d);
    check(d, 8'h00);
    end_test("reset");
    // local payload command, summed response
    mailbox_host_i.issue(16'h0141, 16'h0000, 8'h02, 1'b0);
    wait_start(1'b1);
    check(cmd_code, 16'h0141);
    check(loc_len, 8'h02);
    respond(8'h03, 1'b1);
    // response byte 2 sits at offset 138 for the host to read
    mailbox_host_i.rd(8'h8A, d);
    check(d, 8'h52);
    end_test("payload");
    // every response length class, extended length at its limit
    for (i = 0; i < 5; i++) begin
      mailbox_host_i.issue(16'h0200 + i[15:0], 16'h0800, 8'h00, 1'b0);
      wait_start(1'b1);
      check(ext_len, 16'h0800);
      respond(rl[i], rs[i]);
    end
    end_test("responses");
    // wrong check code, then extended length one past its limit
    mailbox_host_i.issue(16'h0300, 16'h0000, 8'h01, 1'b1);
    wait_start(1'b0);
    mailbox_host_i.issue(16'h0301, 16'h0801, 8'h00, 1'b0);
    wait_start(1'b0);
    mailbox_host_i.rd(8'h86, d);
    check(d, 8'h00);
    mailbox_host_i.rd(8'h87, d);
    check(d, 8'h00);
    end_test("reject");
    // stop-condition trigger waits for the stop
    trigger_at_stop = 1'b1;
    mailbox_host_i.issue(16'h0400, 16'h0000, 8'h00, 1'b0);
    repeat (3) @(negedge clk);
    check(busy, 1'b0);
    mailbox_host_i.stop();
    wait_start(1'b1);
    respond(8'h00, 1'b1);
    trigger_at_stop = 1'b0;
    end_test("stop");
    // hidden page ignores writes and reads zero
    block_implemented = 1'b0;
    mailbox_host_i.wr(8'h84, 8'h5A);
    mailbox_host_i.rd(8'h84, d);
    check(d, 8'h00);
    block_implemented = 1'b1;
    mailbox_host_i.rd(8'h84, d);
    check(d, 8'h00);
    mailbox_host_i.wr(8'h84, 8'h5A);
    mailbox_host_i.rd(8'h84, d);
    check(d, 8'h5A);
    end_test("hidden");
    finish_test();
  end
endmodule
